// *** common/rtcap_regs.svh ***
// Constants for the real-time clock host bus port.
`ifndef RTCAP_REGS_SVH
`define RTCAP_REGS_SVH
// ==========================================================
// Widths and sizes
`define RTCAP_IDX_W      4
`define RTCAP_DATA_W     8
`define RTCAP_REG_CNT    16
// ==========================================================
// Reset values
`define RTCAP_REG_RST    8'h00
`define RTCAP_IDX_RST    4'h0
// ==========================================================
// Port state codes
`define RTCAP_ST_IDLE    4'h1
`define RTCAP_ST_READ    4'h2
`define RTCAP_ST_WRITE   4'h4
`define RTCAP_ST_MUTE    4'h8
`endif

// *** common/rtcap_pkg.sv ***
// Types shared by the real-time clock host bus port.
`include "rtcap_regs.svh"
package rtcap_pkg;
  // ==========================================================
  // Port state
  typedef enum logic [3:0] {
    RTCAP_IDLE  = `RTCAP_ST_IDLE,
    RTCAP_READ  = `RTCAP_ST_READ,
    RTCAP_WRITE = `RTCAP_ST_WRITE,
    RTCAP_MUTE  = `RTCAP_ST_MUTE
  } rtcap_state_t;
  // ==========================================================
  // Committed register write
  typedef struct packed {
    logic [`RTCAP_IDX_W-1:0]  index;
    logic [`RTCAP_DATA_W-1:0] data;
  } rtcap_wr_t;
endpackage

// *** design/rtcap_mem.sv ***
// Sixteen-byte register store with a registered read port.
`timescale 1ns/1ps
`include "rtcap_regs.svh"
module rtcap_mem #(
  parameter int DATA_W = `RTCAP_DATA_W,
  parameter int IDX_W  = `RTCAP_IDX_W,
  parameter int DEPTH  = `RTCAP_REG_CNT
) (
  // Clock, reset and enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              en_i,
  // Write port
  input  wire logic              we_i,
  input  wire logic [IDX_W-1:0]  waddr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // Read port
  input  wire logic [IDX_W-1:0]  raddr_i,
  output logic      [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem_q [DEPTH];

  // ==========================================================
  // Storage
  // Cleared at reset so a read before any write returns a known byte.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= DATA_W'(`RTCAP_REG_RST);
      end
    end else if (en_i && we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // ==========================================================
  // Read register
  // A read in the cycle of a write to the same byte returns the old byte.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= DATA_W'(`RTCAP_REG_RST);
    end else if (en_i) begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule

// *** design/rtcap_port.sv ***
// Byte-wide asynchronous host bus port of the real-time clock.
`timescale 1ns/1ps
`include "rtcap_regs.svh"
// Operation
// [R1] The write strobe is what commits bus data into a register.
// [R2] A write happens only while select and write strobe are both low.
// [R3] A write starts at the later of the two falling edges.
// [R4] A write ends at the first rising edge of select or write strobe.
// [R5] Host keeps select or write strobe high while the index changes.
// [R6] Host keeps the write strobe high through any read cycle.
// [R7] Output enable high keeps the data lines undriven, even in a write.
// [R8] Select falling with or after write strobe means no drive that cycle.
// [R9] Select, output enable low, strobe high: drive the indexed byte, tracking index.
// [R10] Four index lines pick one of sixteen byte registers.
// [R11] Output enable is the read control gating data onto the lines.
// [R12] Every transfer is one byte over eight shared two-way data lines.
// [R13] The byte on the data lines is stored when the write ends.
module rtcap_port
  import rtcap_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     en_i,
  // Host bus strobes, active low
  input  wire logic                     sel_n_i,
  input  wire logic                     wr_n_i,
  input  wire logic                     oe_n_i,
  // Host bus index and data
  input  wire logic [`RTCAP_IDX_W-1:0]  reg_index_lines_i,
  input  wire logic [`RTCAP_DATA_W-1:0] data_lines_i,
  output logic      [`RTCAP_DATA_W-1:0] data_lines_o,
  output logic                          data_lines_oe_n_o,
  // Committed write towards the clock core
  output logic                          wr_stb_o,
  output rtcap_pkg::rtcap_wr_t          wr_o
);
  import rtcap_pkg::*;

  rtcap_state_t              state_q;
  rtcap_state_t              state_d;
  logic                      mute_q;
  logic [`RTCAP_IDX_W-1:0]   cap_index_q;
  logic [`RTCAP_DATA_W-1:0]  cap_data_q;
  logic [`RTCAP_IDX_W-1:0]   rd_index_q;
  logic                      overlap;
  logic                      wr_end;
  logic                      commit;

  // ==========================================================
  // Strobe decode
  assign overlap = !sel_n_i && !wr_n_i; // R2
  assign wr_end  = (state_q == RTCAP_WRITE) && (sel_n_i || wr_n_i); // R4
  assign commit  = en_i && wr_end; // R1

  // ==========================================================
  // Cycle state machine
  // Pins are sampled on the clock, so a strobe edge is seen as a level change.
  always_comb begin
    state_d = state_q;
    case (state_q)
      RTCAP_IDLE: begin
        if (overlap) begin
          state_d = RTCAP_WRITE; // R3
        end else if (!sel_n_i) begin
          state_d = RTCAP_READ;
        end
      end
      RTCAP_READ: begin
        if (sel_n_i) begin
          state_d = RTCAP_IDLE;
        end else if (!wr_n_i) begin
          state_d = RTCAP_WRITE; // R3
        end
      end
      RTCAP_WRITE: begin
        if (sel_n_i) begin
          state_d = RTCAP_IDLE; // R4
        end else if (wr_n_i) begin
          state_d = mute_q ? RTCAP_MUTE : RTCAP_READ; // R4
        end
      end
      RTCAP_MUTE: begin
        if (sel_n_i) begin
          state_d = RTCAP_IDLE;
        end else if (!wr_n_i) begin
          state_d = RTCAP_WRITE;
        end
      end
      default: begin
        state_d = RTCAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= RTCAP_IDLE;
    end else if (en_i) begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Select-after-strobe mute
  // Held for the whole select period so a late select never turns the bus around.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mute_q <= 1'b0;
    end else if (en_i) begin
      if (sel_n_i) begin
        mute_q <= 1'b0;
      end else if (state_q == RTCAP_IDLE && !wr_n_i) begin
        mute_q <= 1'b1; // R8
      end
    end
  end

  // ==========================================================
  // Write capture and commit
  // The host may release data with the ending strobe, so the last overlap byte is kept.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_index_q <= `RTCAP_IDX_RST;
      cap_data_q  <= `RTCAP_REG_RST;
    end else if (en_i && overlap) begin
      cap_index_q <= reg_index_lines_i; // R10
      cap_data_q  <= data_lines_i; // R12
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_stb_o <= 1'b0;
      wr_o     <= '0;
    end else if (en_i) begin
      wr_stb_o <= commit; // R1
      if (commit) begin
        wr_o.index <= cap_index_q; // R13
        wr_o.data  <= cap_data_q; // R13
      end
    end
  end

  // ==========================================================
  // Register store and read path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_index_q <= `RTCAP_IDX_RST;
    end else if (en_i) begin
      rd_index_q <= reg_index_lines_i;
    end
  end

  rtcap_mem #(
    .DATA_W (`RTCAP_DATA_W),
    .IDX_W  (`RTCAP_IDX_W),
    .DEPTH  (`RTCAP_REG_CNT)
  ) u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (en_i),
    .we_i    (commit),
    .waddr_i (cap_index_q),
    .wdata_i (cap_data_q),
    .raddr_i (reg_index_lines_i), // R10
    .rdata_o (data_lines_o) // R9
  );

  // ==========================================================
  // Data line drive
  // Read data lag the index by one cycle; the host must allow for that access time.
  assign data_lines_oe_n_o = !((state_q == RTCAP_READ) && !sel_n_i && wr_n_i
                              && !oe_n_i && !mute_q); // R7 R8 R9 R11

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_overlap;
    en_i && state_q == RTCAP_WRITE && overlap;
  endsequence

  sequence s_wr_end;
    en_i && wr_end;
  endsequence

  write_start_a: assert property ( // R3
    en_i && state_q == RTCAP_IDLE && overlap |=> state_q == RTCAP_WRITE && mute_q)
    else $error("Write did not start on strobe overlap.");

  read_to_write_a: assert property ( // R3
    en_i && state_q == RTCAP_READ && overlap |=> state_q == RTCAP_WRITE && !mute_q)
    else $error("Strobe after select did not start a write.");

  write_end_a: assert property ( // R4
    s_wr_end |=> wr_stb_o && state_q != RTCAP_WRITE)
    else $error("Write did not end on first rising strobe.");

  no_stray_a: assert property ( // R2
    wr_stb_o && $past(en_i) |-> $past(state_q) == RTCAP_WRITE && $past(sel_n_i || wr_n_i))
    else $error("Register write outside a strobe overlap.");

  commit_byte_a: assert property ( // R13
    s_overlap ##1 s_wr_end |=> wr_o.data == $past(data_lines_i, 2)
                               && wr_o.index == $past(reg_index_lines_i, 2))
    else $error("Committed byte differs from last overlap byte.");

  strobe_commit_a: assert property ( // R1
    wr_stb_o |=> !wr_stb_o || !$past(en_i))
    else $error("Write strobe output lasted more than one cycle.");

  oe_hiz_a: assert property ( // R7
    oe_n_i || overlap |-> data_lines_oe_n_o)
    else $error("Data lines driven with output enable high or in a write.");

  mute_hold_a: assert property ( // R8
    en_i && state_q == RTCAP_IDLE && overlap ##1 !sel_n_i [*2] |-> data_lines_oe_n_o)
    else $error("Data lines driven after select fell with the strobe.");

  read_drive_a: assert property ( // R9
    state_q == RTCAP_READ && !sel_n_i && !oe_n_i && wr_n_i && !mute_q
      |-> !data_lines_oe_n_o)
    else $error("Read cycle did not drive the data lines.");

  index_track_a: assert property ( // R10
    en_i && !rst_i |=> rd_index_q == $past(reg_index_lines_i))
    else $error("Read index did not follow the index lines.");

  write_read_a: assert property ( // R13
    wr_stb_o && en_i && rd_index_q == wr_o.index ##1 en_i && $stable(rd_index_q)
      |-> data_lines_o == wr_o.data)
    else $error("Read data do not show the byte just written.");
endmodule

// *** sim/rtcap_host.sv ***
// Host bus master model that drives the port's strobes, index and data.
`timescale 1ns/1ps
module rtcap_host (
  // Clock
  input  wire logic       clk_i,
  // Host bus
  output logic            sel_n_o,
  output logic            wr_n_o,
  output logic            oe_n_o,
  output logic [3:0]      idx_o,
  output logic [7:0]      data_o,
  // Drive must stay off
  output logic            no_drive_o
);
  logic [7:0] data_q;
  logic       drive_q;
  // Released lines show the inverse byte so a stale value never passes.
  assign data_o = drive_q ? data_q : ~data_q;
  initial begin
    sel_n_o = 1'b1;
    wr_n_o = 1'b1;
    oe_n_o = 1'b1;
    idx_o = 4'h0;
    data_q = 8'h00;
    drive_q = 1'b0;
    no_drive_o = 1'b0;
  end
  task automatic write_byte(input bit sf, input bit es, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk_i);
    idx_o <= i;
    data_q <= d;
    drive_q <= 1'b1;
    oe_n_o <= sf;
    no_drive_o <= 1'b1;
    @(posedge clk_i);
    if (sf) sel_n_o <= 1'b0;
    else wr_n_o <= 1'b0;
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    data_q <= ~d;
    if (es) sel_n_o <= 1'b1;
    else wr_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    sel_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    oe_n_o <= 1'b1;
    @(posedge clk_i);
    drive_q <= 1'b0;
    no_drive_o <= 1'b0;
  endtask
  task automatic pulse_alone(input logic [3:0] i, input logic [7:0] d);
    @(posedge clk_i);
    idx_o <= i;
    data_q <= d;
    drive_q <= 1'b1;
    @(posedge clk_i);
    wr_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    wr_n_o <= 1'b1;
    @(posedge clk_i);
    drive_q <= 1'b0;
  endtask
  task automatic rd_start(input logic [3:0] i);
    @(posedge clk_i);
    idx_o <= i;
    sel_n_o <= 1'b0;
    oe_n_o <= 1'b0;
    wr_n_o <= 1'b1;
  endtask
  task automatic set_idx(input logic [3:0] i);
    @(posedge clk_i);
    idx_o <= i;
  endtask
  task automatic set_pins(input logic s, input logic o);
    @(posedge clk_i);
    sel_n_o <= s;
    oe_n_o <= o;
  endtask
endmodule

// *** sim/test_rtcap_port.sv ***
// Self-checking testbench of the host bus port.
`timescale 1ns/1ps
module test_rtcap_port;
  import rtcap_pkg::*;
  logic       clk_i;
  logic       rst_i;
  logic       sel_n, wr_n, oe_n, no_drv, en;
  logic [3:0] idx;
  logic [7:0] host_d, bus, dout;
  logic       oe_n_dev, wr_stb;
  rtcap_wr_t  wr;
  int         err_count, checks, stb_cnt, drv_cnt;
  logic [7:0] model [16];
  assign bus = (oe_n_dev === 1'b0) ? dout : host_d;
  rtcap_host host (.clk_i(clk_i), .sel_n_o(sel_n), .wr_n_o(wr_n), .oe_n_o(oe_n),
    .idx_o(idx), .data_o(host_d), .no_drive_o(no_drv));
  rtcap_port u_rtcap_port (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .sel_n_i(sel_n),
    .wr_n_i(wr_n), .oe_n_i(oe_n), .reg_index_lines_i(idx), .data_lines_i(bus),
    .data_lines_o(dout), .data_lines_oe_n_o(oe_n_dev), .wr_stb_o(wr_stb), .wr_o(wr));
  always @(negedge clk_i) begin
    if (wr_stb === 1'b1) stb_cnt++;
    if (no_drv && oe_n_dev !== 1'b1) drv_cnt++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic sc_write(input bit sf, input bit es, input logic [3:0] i, input logic [7:0] d);
    int s0 = stb_cnt;
    int d0 = drv_cnt;
    host.write_byte(sf, es, i, d);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    model[i] = d;
    check(16'(stb_cnt - s0), 16'h0001);
    check({4'h0, wr}, {4'h0, i, d});
    check(16'(drv_cnt - d0), 16'h0000);
  endtask
  task automatic sc_no_overlap();
    int s0 = stb_cnt;
    host.pulse_alone(4'h3, 8'h00);
    repeat (3) @(posedge clk_i);
    check(16'(stb_cnt - s0), 16'h0000);
    check({4'h0, wr}, 16'h0F81);
  endtask
  task automatic sc_read();
    host.rd_start(4'h0);
    for (int i = 0; i < 16; i++) begin
      host.set_idx(4'(i));
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check({15'h0, oe_n_dev}, 16'h0000);
      check({8'h00, bus}, {8'h00, model[i]});
    end
    // Clock enable low must freeze the read register while the index moves.
    @(posedge clk_i);
    en <= 1'b0;
    host.set_idx(4'h3);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({8'h00, bus}, {8'h00, model[15]});
    @(posedge clk_i);
    en <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({8'h00, bus}, {8'h00, model[3]});
    host.set_pins(1'b0, 1'b1);
    @(negedge clk_i);
    check({15'h0, oe_n_dev}, 16'h0001);
    host.set_pins(1'b1, 1'b1);
  endtask
  task automatic sc_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) model[i] = 8'h00;
    @(negedge clk_i);
    check({4'h0, wr}, 16'h0000);
    host.rd_start(4'h3);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({8'h00, bus}, {8'h00, model[3]});
    host.set_pins(1'b1, 1'b1);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #500_000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    // ==========================================================
    // Main sequence
    rst_i = 1'b1;
    en = 1'b1;
    for (int i = 0; i < 16; i++) model[i] = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_write(1'b1, 1'b0, 4'h3, 8'hA5);
    sc_write(1'b0, 1'b1, 4'h9, 8'h3C);
    sc_write(1'b1, 1'b1, 4'h0, 8'hFF);
    sc_write(1'b0, 1'b0, 4'hF, 8'h81);
    sc_no_overlap();
    sc_read();
    sc_reset();
    tally_and_finish();
  end
endmodule
